/* File: rtl/uhp_pkg.sv */
// shared constants, register map and state types of the host parallel port
package uhp_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 16;
  localparam int CFG_W  = 5;
  localparam int EV_W   = 6;
  localparam int SYNC_W = 27;

  // ==========================================================================
  // bus configuration selector codes
  localparam logic [1:0] CFG_MUX   = 2'h0;
  localparam logic [1:0] CFG_SPLIT = 2'h1;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0c;
  localparam logic [7:0] OFF_CMD    = 8'h10;
  localparam logic [7:0] OFF_HWR    = 8'h14;
  localparam logic [7:0] OFF_HRD    = 8'h18;
  localparam logic [7:0] OFF_DWR    = 8'h1c;
  localparam logic [7:0] OFF_DRD    = 8'h20;
  localparam logic [7:0] OFF_PINS   = 8'h24;

  // ==========================================================================
  // config fields
  localparam int CB_IPOL  = 0;
  localparam int CB_PULSE = 1;
  localparam int CB_DMA_REQUEST_OUT  = 2;
  localparam int CB_DMA_ACK_IN  = 3;
  localparam int CB_EOT   = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h1d;

  // ==========================================================================
  // control fields
  localparam int CB_DMAEN = 0;
  localparam int CB_REL   = 1;
  localparam int CB_BUSY  = 2;

  // ==========================================================================
  // event bits of status and mask
  localparam int EV_CMD  = 0;
  localparam int EV_DWR  = 1;
  localparam int EV_DRD  = 2;
  localparam int EV_DMAW = 3;
  localparam int EV_DMAR = 4;
  localparam int EV_EOT  = 5;

  // ==========================================================================
  // timing
  localparam logic [3:0] INT_PULSE_CYC = 4'h4;

  // ==========================================================================
  // pin synchroniser idle levels: strobes high, select high, rest low
  localparam logic [SYNC_W-1:0] SYNC_INIT = 27'h74c0000;

  // ==========================================================================
  // state
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WR   = 4'b0010,
    BUS_RDW  = 4'b0100,
    BUS_RDD  = 4'b1000
  } uhp_bus_e;

  typedef struct packed {
    uhp_bus_e           bus;
    logic [7:0]         addr;
    logic [31:0]        rdata;
    logic [CFG_W-1:0]   cfg;
    logic               dmaEn;
    logic               busy;
    logic [EV_W-1:0]    status;
    logic [EV_W-1:0]    mask;
    logic [DATA_W-1:0]  cmdWord;
    logic [DATA_W-1:0]  hostWr;
    logic [DATA_W-1:0]  hostRd;
    logic [DATA_W-1:0]  dmaWr;
    logic [DATA_W-1:0]  dmaRd;
    logic               addrBit;
    logic               wrPrev;
    logic               rdPrev;
    logic               dwPrev;
    logic               drPrev;
    logic               alePrev;
    logic               eotPrev;
    logic [DATA_W-1:0]  dout;
    logic               doutOeN;
    logic [3:0]         pulseCnt;
    logic               intOut;
    logic               dreqOut;
    logic               irq;
  } uhp_state_s;

  localparam uhp_state_s ST_RST = '{
    bus: BUS_IDLE, cfg: CFG_RST, addrBit: 1'b1, wrPrev: 1'b1, rdPrev: 1'b1,
    dwPrev: 1'b1, drPrev: 1'b1, doutOeN: 1'b1, default: '0
  };

endpackage : uhp_pkg

/* File: rtl/uhp_pin_sync.sv */
// two-flop synchroniser bank for the asynchronous host pins
`timescale 1ns/1ps
module uhp_pin_sync
  import uhp_pkg::*;
#(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [W-1:0]  pinIn,
  output logic      [W-1:0]  pinOut
);

  // ==========================================================================
  // stage 0 is read only by stage 1
  logic [1:0][W-1:0] st;
  logic [1:0][W-1:0] next_st;

  always_comb begin
    next_st = {st[0], pinIn};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= {INIT, INIT};
    end else begin
      st <= next_st;
    end
  end

  assign pinOut = st[1];

endmodule : uhp_pin_sync

/* File: rtl/uhp_host_port.sv */
// host parallel pio/dma pin logic with ahb-lite register slave
//
// Function
// - a dma transfer starts when the dma acknowledge input reaches its programmed level.
// - the dedicated dma strobes count only in configuration 1 and are ignored otherwise.
// - the interrupt pin has programmable active level and level or pulse signalling.
// - ready goes low while an earlier command or data word is processed; host waits.
// - ready high means the device will complete the current pio transfer.
// - ready governs pio transfers only, never the separate dma port.
// - data travel on a 16-bit two-way bus, driven on reads and sampled on writes.
// - in multiplexed mode the falling edge of address latch captures line 0 as address.
// - address bit 1 selects the command register and 0 the data register.
// - in multiplexed data phase line 0 carries data bit 0 both ways.
// - a dma request output of programmable polarity asks for a dma transfer.
// - an end-of-transfer input of programmable polarity ends the current dma transfer.
`timescale 1ns/1ps
module uhp_host_port
  import uhp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               csN,
  input  wire logic               rdN,
  input  wire logic               wrN,
  input  wire logic               aleIn,
  input  wire logic               cmdDataSelect,
  input  wire logic               busCfgSelHi,
  input  wire logic               busCfgSelLo,
  input  wire logic               dmaPortWriteStrobeN,
  input  wire logic               dmaPortReadStrobeN,
  input  wire logic               dmaAckIn,
  input  wire logic               transferEndIn,
  input  wire logic [DATA_W-1:0]  dataIn,
  output logic      [DATA_W-1:0]  dataOut,
  output logic                    dataOeN,
  output logic                    readyOut,
  output logic                    intOut,
  output logic                    dmaRequestOut,
  output logic                    irq
);

  // ==========================================================================
  // pin synchronisers
  logic [SYNC_W-1:0] pinS;
  logic              sCsN;
  logic              sRdN;
  logic              sWrN;
  logic              sAle;
  logic              sCmdSel;
  logic              sDwN;
  logic              sDrN;
  logic              sAck;
  logic              sEot;
  logic [1:0]        cfgSel;
  logic [DATA_W-1:0] sData;

  uhp_pin_sync #(
    .W    (SYNC_W),
    .INIT (SYNC_INIT)
  ) uSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   ({csN, rdN, wrN, aleIn, cmdDataSelect, busCfgSelHi, busCfgSelLo,
               dmaPortWriteStrobeN, dmaPortReadStrobeN, dmaAckIn, transferEndIn, dataIn}),
    .pinOut  (pinS)
  );

  assign sCsN    = pinS[26];
  assign sRdN    = pinS[25];
  assign sWrN    = pinS[24];
  assign sAle    = pinS[23];
  assign sCmdSel = pinS[22];
  assign cfgSel  = pinS[21:20]; // static selector straps
  assign sDwN    = pinS[19];
  assign sDrN    = pinS[18];
  assign sAck    = pinS[17];
  assign sEot    = pinS[16];
  assign sData   = pinS[15:0];

  // ==========================================================================
  // state
  uhp_state_s st;
  uhp_state_s next_st;

  // ==========================================================================
  // pin decode
  logic muxMode;
  logic splitMode;
  logic ackAct;
  logic eotAct;
  logic aleFall;
  logic selCmd;
  logic pioSel;
  logic wrRise;
  logic rdRise;
  logic dwRise;
  logic drRise;
  logic pioWr;
  logic pioRd;
  logic shDma;
  logic dmaWrEv;
  logic dmaRdEv;
  logic pioDrive;
  logic dmaDrive;
  logic accept;

  assign muxMode   = (cfgSel == CFG_MUX);
  assign splitMode = (cfgSel == CFG_SPLIT);
  assign ackAct    = (sAck == st.cfg[CB_DMA_ACK_IN]);
  assign eotAct    = (sEot == st.cfg[CB_EOT]);
  // latch strobe looked at only in multiplexed mode, so a held-low strobe is harmless
  assign aleFall   = muxMode & st.alePrev & ~sAle;
  assign selCmd    = muxMode ? st.addrBit : sCmdSel;
  assign pioSel    = ~sCsN;
  assign wrRise    = ~st.wrPrev & sWrN;
  assign rdRise    = ~st.rdPrev & sRdN;
  assign dwRise    = ~st.dwPrev & sDwN;
  assign drRise    = ~st.drPrev & sDrN;
  // words arriving while busy are dropped; the host must wait for ready
  assign pioWr     = pioSel & wrRise & ~st.busy;
  assign pioRd     = pioSel & rdRise & ~st.busy;
  // shared port: strobes with chip select off and acknowledge on are dma cycles
  assign shDma     = ~splitMode & ~pioSel & ackAct;
  assign dmaWrEv   = splitMode ? (ackAct & dwRise) : (shDma & wrRise);
  assign dmaRdEv   = splitMode ? (ackAct & drRise) : (shDma & rdRise);
  assign pioDrive  = pioSel & ~sRdN;
  assign dmaDrive  = splitMode ? (ackAct & ~sDrN) : (shDma & ~sRdN);
  assign accept    = hsel & htrans[1] & hready;

  // ==========================================================================
  // register read mux
  function automatic logic [31:0] regRead(input uhp_state_s s, input logic [1:0] sel);
    logic [31:0] r;
    r = 32'h0;
    case (s.addr)
      OFF_CONFIG: r = {27'h0, s.cfg};
      OFF_CTRL:   r = {29'h0, s.busy, 1'b0, s.dmaEn};
      OFF_STATUS: r = {26'h0, s.status};
      OFF_MASK:   r = {26'h0, s.mask};
      OFF_CMD:    r = {16'h0, s.cmdWord};
      OFF_HWR:    r = {16'h0, s.hostWr};
      OFF_HRD:    r = {16'h0, s.hostRd};
      OFF_DWR:    r = {16'h0, s.dmaWr};
      OFF_DRD:    r = {16'h0, s.dmaRd};
      OFF_PINS:   r = {30'h0, sel};
      default:    r = 32'h0;
    endcase
    return r;
  endfunction : regRead

  // ==========================================================================
  // next state
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] stClr;
  logic            rel;
  logic            intActive;

  always_comb begin
    next_st   = st;
    evSet     = '0;
    stClr     = '0;
    rel       = 1'b0;
    intActive = 1'b0;
    next_st.wrPrev  = sWrN;
    next_st.rdPrev  = sRdN;
    next_st.dwPrev  = sDwN;
    next_st.drPrev  = sDrN;
    next_st.alePrev = sAle;
    next_st.eotPrev = eotAct;
    if (aleFall) begin
      next_st.addrBit = sData[0];
    end
    if (pioWr) begin
      if (selCmd) begin
        next_st.cmdWord = sData;
        evSet[EV_CMD]   = 1'b1;
      end else begin
        next_st.hostWr  = sData; // bit 0 from the shared line
        evSet[EV_DWR]   = 1'b1;
      end
    end
    evSet[EV_DRD] = pioRd & ~selCmd;
    if (dmaWrEv) begin
      next_st.dmaWr  = sData;
      evSet[EV_DMAW] = 1'b1;
    end
    evSet[EV_DMAR] = dmaRdEv;
    evSet[EV_EOT]  = eotAct & ~st.eotPrev;
    // drive only while a strobe is low; enable lags the pin by the sync delay
    if (pioDrive) begin
      next_st.dout    = selCmd ? st.cmdWord : st.hostRd;
      next_st.doutOeN = 1'b0;
    end else if (dmaDrive) begin
      next_st.dout    = st.dmaRd;
      next_st.doutOeN = 1'b0;
    end else begin
      next_st.doutOeN = 1'b1;
    end
    // bus slave: writes land in the data phase, reads take one wait state
    case (st.bus)
      BUS_WR: begin
        case (st.addr)
          OFF_CONFIG: next_st.cfg = hwdata[CFG_W-1:0];
          OFF_CTRL: begin
            next_st.dmaEn = hwdata[CB_DMAEN];
            rel           = hwdata[CB_REL];
          end
          OFF_MASK:   next_st.mask   = hwdata[EV_W-1:0];
          OFF_HRD:    next_st.hostRd = hwdata[DATA_W-1:0];
          OFF_DRD:    next_st.dmaRd  = hwdata[DATA_W-1:0];
          default:    ;
        endcase
      end
      BUS_RDW: begin
        next_st.rdata = regRead(st, cfgSel);
        stClr = {EV_W{st.addr == OFF_STATUS}}; // a same-cycle event still wins below
      end
      default: ;
    endcase
    if (st.bus == BUS_RDW) begin
      next_st.bus = BUS_RDD;
    end else if (accept) begin
      next_st.bus  = hwrite ? BUS_WR : BUS_RDW;
      next_st.addr = haddr[7:0];
    end else begin
      next_st.bus = BUS_IDLE;
    end
    // busy: a new word wins over a release in the same cycle
    if (pioWr || (pioRd && !selCmd)) begin
      next_st.busy = 1'b1;
    end else if (rel) begin
      next_st.busy = 1'b0;
    end
    if (eotAct) begin
      next_st.dmaEn = 1'b0;
    end
    next_st.dreqOut = st.cfg[CB_DMA_REQUEST_OUT] ? next_st.dmaEn : ~next_st.dmaEn;
    next_st.status  = (st.status & ~stClr) | evSet;
    if (|(evSet & st.mask)) begin
      next_st.pulseCnt = INT_PULSE_CYC;
    end else if (st.pulseCnt != 4'h0) begin
      next_st.pulseCnt = st.pulseCnt - 4'h1;
    end
    next_st.irq = |(next_st.status & st.mask);
    intActive   = st.cfg[CB_PULSE] ? (next_st.pulseCnt != 4'h0) : next_st.irq;
    next_st.intOut = st.cfg[CB_IPOL] ? intActive : ~intActive;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign hreadyout     = (st.bus != BUS_RDW);
  assign hresp         = 1'b0;
  assign hrdata        = st.rdata;
  assign dataOut       = st.dout;
  assign dataOeN       = st.doutOeN;
  // dma traffic never touches busy, so ready reflects pio only
  assign readyOut      = ~st.busy;
  assign intOut        = st.intOut;
  assign dmaRequestOut = st.dreqOut;
  assign irq           = st.irq;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_intHeld;
    (intOut == st.cfg[CB_IPOL]) [*4];
  endsequence

  a_ready_drops: assert property (
    pioWr |=> !readyOut
  ) else $error("ready stayed high after an accepted pio write");
  a_ready_release: assert property (
    (st.bus == BUS_WR && st.addr == OFF_CTRL && hwdata[CB_REL] && !pioWr && !pioRd)
      |=> readyOut
  ) else $error("ready not restored by release");
  a_dma_no_ready: assert property (
    (dmaWrEv || dmaRdEv) && !pioWr && !pioRd && !(st.bus == BUS_WR)
      |=> $stable(readyOut)
  ) else $error("dma cycle changed ready");
  a_split_ignore: assert property (
    (!splitMode && dwRise && !wrRise) |=> $stable(st.dmaWr)
  ) else $error("dedicated dma strobe used outside configuration 1");
  a_dma_capture: assert property (
    (splitMode && ackAct && dwRise) |=> (st.dmaWr == $past(sData))
  ) else $error("acknowledged dma write not captured");
  a_int_level: assert property (
    (!st.cfg[CB_PULSE] && $stable(st.cfg)) |-> (intOut == (st.cfg[CB_IPOL] ? irq : ~irq))
  ) else $error("level interrupt disagrees with pending events");
  a_int_pulse: assert property (
    (st.cfg[CB_PULSE] && |(evSet & st.mask) && $stable(st.cfg)) |=> s_intHeld
  ) else $error("interrupt pulse shorter than four cycles");
  a_ale_latch: assert property (
    aleFall |=> (st.addrBit == $past(sData[0]))
  ) else $error("address bit not latched on latch strobe fall");
  a_cmd_select: assert property (
    (pioWr && selCmd) |=> (st.cmdWord == $past(sData)) && $stable(st.hostWr)
  ) else $error("command write went to the wrong register");
  a_data_bit0: assert property (
    (pioWr && !selCmd) |=> (st.hostWr[0] == $past(sData[0]))
  ) else $error("data bit 0 not taken from the shared line");
  a_cs_float: assert property (
    (sCsN && !dmaDrive) |=> dataOeN
  ) else $error("data bus driven with chip select inactive");
  a_dma_request_out_level: assert property (
    (st.dmaEn && !eotAct && $stable(st.cfg)) |-> (dmaRequestOut == st.cfg[CB_DMA_REQUEST_OUT])
  ) else $error("dma request not at its programmed level");
  a_eot_stop: assert property (
    (eotAct && st.dmaEn) |=> !st.dmaEn ##1 (dmaRequestOut != st.cfg[CB_DMA_REQUEST_OUT])
  ) else $error("end of transfer did not stop the dma request");

endmodule : uhp_host_port

/* File: tb/uhp_host_model.sv */
// host cpu and dma controller model on the far side of the pio pins
`timescale 1ns/1ps
module uhp_host_model
  import uhp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic [DATA_W-1:0]  dataOut,
  input  wire logic               dataOeN,
  input  wire logic               readyOut,
  output logic                    csN,
  output logic                    rdN,
  output logic                    wrN,
  output logic                    aleIn,
  output logic                    cmdDataSelect,
  output logic                    busCfgSelHi,
  output logic                    busCfgSelLo,
  output logic                    dmaPortWriteStrobeN,
  output logic                    dmaPortReadStrobeN,
  output logic                    dmaAckIn,
  output logic                    transferEndIn,
  output logic      [DATA_W-1:0]  dataIn
);
  logic              drvEn = 1'b0;
  logic [DATA_W-1:0] drv = '0;
  logic [DATA_W-1:0] lastBus = '0;
  logic              mux = 1'b0;
  // ==========
  // bus wire
  // released bus toggles each cycle so a stale value never passes
  assign dataIn = drvEn ? drv : (!dataOeN ? dataOut : ~lastBus);
  always @(posedge sys_clk) lastBus <= dataIn;
  initial begin
    {csN, rdN, wrN, dmaPortWriteStrobeN, dmaPortReadStrobeN} = 5'h1f;
    {aleIn, dmaAckIn, transferEndIn} = 3'h0;
    cmdDataSelect = 1'b1;
    {busCfgSelHi, busCfgSelLo} = 2'h2;
  end
  // ==========
  // pin tasks
  task automatic setCfg(input logic [1:0] c);
    @(posedge sys_clk);
    {busCfgSelHi, busCfgSelLo} <= c;
    mux <= (c == CFG_MUX);
    cmdDataSelect <= 1'b1;
    aleIn <= 1'b0;
  endtask : setCfg
  task automatic pioWrite(input logic cs, input logic sel, input logic obey,
                          input logic [DATA_W-1:0] d);
    while (obey && readyOut !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    csN <= ~cs;
    if (!mux) cmdDataSelect <= sel;
    drvEn <= 1'b1;
    drv <= d;
    wrN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wrN <= 1'b1;
    repeat (2) @(posedge sys_clk);
    csN <= 1'b1;
    drvEn <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : pioWrite
  task automatic pioRead(input logic cs, output logic oeN, output logic [DATA_W-1:0] d);
    while (readyOut !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    csN <= ~cs;
    rdN <= 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    oeN = dataOeN;
    d = dataOut;
    @(posedge sys_clk);
    rdN <= 1'b1;
    repeat (2) @(posedge sys_clk);
    csN <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : pioRead
  task automatic muxAddr(input logic a);
    @(posedge sys_clk);
    drvEn <= 1'b1;
    drv <= {15'h0, a};
    aleIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    aleIn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    drvEn <= 1'b0;
  endtask : muxAddr
  task automatic dmaWrite(input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    dmaAckIn <= 1'b1;
    drvEn <= 1'b1;
    drv <= d;
    repeat (3) @(posedge sys_clk);
    dmaPortWriteStrobeN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    dmaPortWriteStrobeN <= 1'b1;
    repeat (3) @(posedge sys_clk);
    dmaAckIn <= 1'b0;
    drvEn <= 1'b0;
  endtask : dmaWrite
  task automatic dmaRead(output logic oeN, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    dmaAckIn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    dmaPortReadStrobeN <= 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    oeN = dataOeN;
    d = dataOut;
    @(posedge sys_clk);
    dmaPortReadStrobeN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    dmaAckIn <= 1'b0;
  endtask : dmaRead
  task automatic setAck(input logic a);
    @(posedge sys_clk);
    dmaAckIn <= a;
  endtask : setAck
  task automatic endXfer();
    @(posedge sys_clk);
    transferEndIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    transferEndIn <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : endXfer
endmodule : uhp_host_model

/* File: tb/uhp_host_port_tb.sv */
// self-checking bench of the host parallel port
`timescale 1ns/1ps
module uhp_host_port_tb
  import uhp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic        hreadyout, hresp, rdN, wrN, csN, aleIn, cmdDataSelect;
  logic [31:0] hrdata;
  logic        busCfgSelHi, busCfgSelLo, dmaPortWriteStrobeN, dmaPortReadStrobeN;
  logic        dmaAckIn, transferEndIn, dataOeN, readyOut, intOut, dmaRequestOut, irq;
  logic [15:0] dataIn, dataOut, rdv;
  logic        oeS;
  int          nErrors = 0;
  int          comparisons = 0;
  int          intCnt = 0;
  always #2 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (intOut === 1'b1) intCnt++;
  uhp_host_port uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .csN(csN), .rdN(rdN), .wrN(wrN),
    .aleIn(aleIn), .cmdDataSelect(cmdDataSelect), .busCfgSelHi(busCfgSelHi),
    .busCfgSelLo(busCfgSelLo), .dmaPortWriteStrobeN(dmaPortWriteStrobeN),
    .dmaPortReadStrobeN(dmaPortReadStrobeN), .dmaAckIn(dmaAckIn),
    .transferEndIn(transferEndIn), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
    .readyOut(readyOut), .intOut(intOut), .dmaRequestOut(dmaRequestOut), .irq(irq));
  uhp_host_model host (.sys_clk(sys_clk), .dataOut(dataOut), .dataOeN(dataOeN),
    .readyOut(readyOut), .csN(csN), .rdN(rdN), .wrN(wrN), .aleIn(aleIn),
    .cmdDataSelect(cmdDataSelect), .busCfgSelHi(busCfgSelHi), .busCfgSelLo(busCfgSelLo),
    .dmaPortWriteStrobeN(dmaPortWriteStrobeN), .dmaPortReadStrobeN(dmaPortReadStrobeN),
    .dmaAckIn(dmaAckIn), .transferEndIn(transferEndIn), .dataIn(dataIn));
  // ==========
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  // hready is judged just before the edge, where it is settled
  task automatic waitRdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge sys_clk);
      r = hreadyout;
      d = hrdata;
      @(posedge sys_clk);
    end while (r !== 1'b1);
  endtask : waitRdy
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    waitRdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy(rd);
  endtask : ahb
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : regWr
  task automatic regRd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, '0, x);
    check(nm, x, exp);
    check("respOkay", hresp, 1'b0);
  endtask : regRd
  task automatic restart(input logic [1:0] c);
    host.setCfg(c);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : restart
  // ==========
  // scenarios
  task automatic testPio();
    restart(2'h2);
    check("readyAfterReset", readyOut, 1'b1);
    regRd("configReset", OFF_CONFIG, 32'h1d);
    regRd("unmapped", 8'h40, 32'h0);
    regWr(OFF_MASK, 32'h2);
    host.pioWrite(1'b1, 1'b0, 1'b1, 16'hbeef);
    check("readyBusy", readyOut, 1'b0);
    check("irqLevel", {irq, intOut}, 2'h3);
    host.pioWrite(1'b1, 1'b0, 1'b0, 16'h1111);
    regRd("hostWrDrop", OFF_HWR, 32'hbeef);
    regRd("statusEv", OFF_STATUS, 32'h2);
    settle(1);
    check("irqCleared", irq, 1'b0);
    regWr(OFF_CTRL, 32'h2);
    settle(2);
    check("readyBack", readyOut, 1'b1);
    host.pioWrite(1'b1, 1'b1, 1'b1, 16'h00c5);
    regRd("cmdWord", OFF_CMD, 32'hc5);
    regWr(OFF_CTRL, 32'h2);
    host.pioWrite(1'b0, 1'b0, 1'b1, 16'h7777);
    regRd("csIgnored", OFF_HWR, 32'hbeef);
    regWr(OFF_HRD, 32'h1234);
    host.pioRead(1'b1, oeS, rdv);
    check("readDrive", {oeS, rdv}, {1'b0, 16'h1234});
    settle(4);
    check("readRelease", dataOeN, 1'b1);
    regWr(OFF_CTRL, 32'h2);
    host.pioRead(1'b0, oeS, rdv);
    check("csNoDrive", oeS, 1'b1);
    host.dmaWrite(16'h4242);
    regRd("dedicatedIgnored", OFF_DWR, 32'h0);
    host.setAck(1'b1);
    host.pioWrite(1'b0, 1'b0, 1'b0, 16'h6565);
    host.setAck(1'b0);
    check("readyShared", readyOut, 1'b1);
    regRd("sharedDma", OFF_DWR, 32'h6565);
    $display("test pio done");
  endtask : testPio
  task automatic testDma();
    restart(CFG_SPLIT);
    regWr(OFF_CTRL, 32'h1);
    settle(2);
    check("dmaReq", dmaRequestOut, 1'b1);
    host.dmaWrite(16'h4242);
    check("readyDma", readyOut, 1'b1);
    regRd("dmaWord", OFF_DWR, 32'h4242);
    regWr(OFF_DRD, 32'h5a5a);
    host.dmaRead(oeS, rdv);
    check("dmaRead", {oeS, rdv}, {1'b0, 16'h5a5a});
    regRd("pins", OFF_PINS, 32'h1);
    host.endXfer();
    check("dmaReqEnd", dmaRequestOut, 1'b0);
    regRd("dmaStatus", OFF_STATUS, 32'h38);
    $display("test dma done");
  endtask : testDma
  task automatic testMux();
    restart(CFG_MUX);
    host.muxAddr(1'b1);
    host.pioWrite(1'b1, 1'b0, 1'b1, 16'h0081);
    regRd("muxCmd", OFF_CMD, 32'h81);
    regWr(OFF_CTRL, 32'h2);
    host.muxAddr(1'b0);
    host.pioWrite(1'b1, 1'b1, 1'b1, 16'h0003);
    regRd("muxData", OFF_HWR, 32'h3);
    $display("test mux done");
  endtask : testMux
  task automatic testInt();
    restart(2'h3);
    regWr(OFF_CONFIG, 32'h1f);
    regWr(OFF_MASK, 32'h2);
    intCnt = 0;
    host.pioWrite(1'b1, 1'b0, 1'b1, 16'h0055);
    settle(10);
    check("pulseLen", intCnt, 32'h4);
    regWr(OFF_CONFIG, 32'h1c);
    settle(2);
    check("lowActive", {irq, intOut}, 2'h2);
    regWr(OFF_MASK, 32'h0);
    settle(2);
    check("masked", {irq, intOut}, 2'h1);
    $display("test int done");
  endtask : testInt
  // ==========
  // main and watchdog
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    testPio();
    testDma();
    testMux();
    testInt();
    results();
  end
  // all scenarios need a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    results();
  end
endmodule : uhp_host_port_tb
